// >>> port_pin_logic.sv
// Port pin logic: upper address port, multi-function port, general port one
`timescale 1ns/1ps
`include "port_defines.svh"

module port_pin_logic
  import port_pkg::*;
#(
  parameter int WIDTH = `PORT_WIDTH
) (
  // Clock and reset
  input  logic             clk_sys,
  input  logic             rst_n,
  // Core memory access
  input  logic             mem_access,
  input  logic [15:0]      mem_addr,
  input  logic             mem_indirect,
  input  logic             xdata_rd,
  input  logic             xdata_wr,
  // Core port latch access
  input  logic             upper_wr_en,
  input  logic [WIDTH-1:0] upper_wr_data,
  output logic [WIDTH-1:0] upper_latch,
  input  logic             gen_one_wr_en,
  input  logic [WIDTH-1:0] gen_one_wr_data,
  output logic [WIDTH-1:0] gen_one_latch,
  output logic [WIDTH-1:0] gen_one_read,
  input  logic             multi_wr_en,
  input  logic [WIDTH-1:0] multi_wr_data,
  output logic [WIDTH-1:0] multi_latch,
  output logic [WIDTH-1:0] multi_read,
  // Alternate functions, general port one
  input  logic             timer_two_out,
  output logic             timer_two_pin,
  output logic             timer_two_trigger_pin,
  output logic             serial_one_receive,
  input  logic             serial_one_transmit,
  output logic             ext_irq_two_rising,
  output logic             ext_irq_three_falling,
  output logic             ext_irq_four_rising,
  output logic             ext_irq_five_falling,
  // Alternate functions, multi-function port
  output logic             serial_zero_receive,
  input  logic             serial_zero_transmit,
  output logic             ext_irq_zero,
  output logic             ext_irq_one,
  output logic             timer_zero_count_in,
  output logic             timer_one_count_in,
  output logic             xdata_wr_strobe_n,
  output logic             xdata_rd_strobe_n,
  // Upper address port pins
  output logic [WIDTH-1:0] upper_address_port,
  // General port one pins
  input  logic [WIDTH-1:0] general_port_one_in,
  output logic [WIDTH-1:0] general_port_one_out,
  output logic [WIDTH-1:0] general_port_one_oe,
  output logic [WIDTH-1:0] general_port_one_pullup,
  // Multi-function port pins
  input  logic [WIDTH-1:0] multi_function_port_in,
  output logic [WIDTH-1:0] multi_function_port_out,
  output logic [WIDTH-1:0] multi_function_port_oe,
  output logic [WIDTH-1:0] multi_function_port_pullup
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Upper address port
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] upper_latch_q;
  logic [WIDTH-1:0] addr_pin_q;
  logic [WIDTH-1:0] addr_high;

  // Indirect moves only carry eight address bits, so the latch fills in
  function automatic logic [7:0] high_byte(input logic       indirect,
                                           input logic [15:0] addr,
                                           input logic [7:0]  latch);
    high_byte = indirect ? latch : addr[15:8];
  endfunction

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      upper_latch_q <= `PORT_RESET;
    end else if (upper_wr_en) begin
      upper_latch_q <= upper_wr_data;
    end
  end

  assign upper_latch = upper_latch_q;
  assign addr_high   = high_byte(mem_indirect, mem_addr, upper_latch_q);

  // Pins hold the last address between accesses; the latch reaches them only on indirect moves
  for (genvar i = 0; i < WIDTH; i++) begin : g_addr
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        addr_pin_q[i] <= 1'b1;
      end else if (mem_access) begin
        addr_pin_q[i] <= addr_high[i];
      end
    end
  end

  assign upper_address_port = addr_pin_q;

  // ----------------------------------------------------------------
  // External data strobes
  // ----------------------------------------------------------------
  xfer_e xfer_q;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      xfer_q <= XFER_IDLE;
    end else begin
      case (xfer_q)
        XFER_IDLE, XFER_READ, XFER_WRITE: begin
          if (mem_access && xdata_rd) begin
            xfer_q <= XFER_READ;
          end else if (mem_access && xdata_wr) begin
            xfer_q <= XFER_WRITE;
          end else begin
            xfer_q <= XFER_IDLE;
          end
        end
        default: begin
          xfer_q <= XFER_IDLE;
        end
      endcase
    end
  end

  assign xdata_rd_strobe_n = (xfer_q != XFER_READ);
  assign xdata_wr_strobe_n = (xfer_q != XFER_WRITE);

  // ----------------------------------------------------------------
  // General port one
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] gen_one_alt;

  always_comb begin
    gen_one_alt                  = '1;
    gen_one_alt[`G1_TIMER2_BIT]  = timer_two_out;
    gen_one_alt[`G1_SER1_TX_BIT] = serial_one_transmit;
  end

  quasi_port #(
    .WIDTH      (WIDTH),
    .STRONG_CYC (`STRONG_PULL_CYC),
    .RST_VAL    (`PORT_RESET)
  ) u_gen_one (
    .clk_sys   (clk_sys),
    .rst_n     (rst_sync_n),
    .wr_en     (gen_one_wr_en),
    .wr_data   (gen_one_wr_data),
    .alt_out   (gen_one_alt),
    .latch_q   (gen_one_latch),
    .pin_level (gen_one_read),
    .pin_in    (general_port_one_in),
    .pin_out   (general_port_one_out),
    .pin_oe    (general_port_one_oe),
    .pullup_en (general_port_one_pullup)
  );

  assign timer_two_pin         = gen_one_read[`G1_TIMER2_BIT];
  assign timer_two_trigger_pin = gen_one_read[`G1_T2TRIG_BIT];
  assign serial_one_receive    = gen_one_read[`G1_SER1_RX_BIT];

  edge_catch #(.RISING(1'b1)) u_irq_two (
    .clk_sys (clk_sys),
    .rst_n   (rst_sync_n),
    .level   (gen_one_read[`G1_IRQ2_BIT]),
    .pulse_q (ext_irq_two_rising)
  );

  edge_catch #(.RISING(1'b0)) u_irq_three (
    .clk_sys (clk_sys),
    .rst_n   (rst_sync_n),
    .level   (gen_one_read[`G1_IRQ3_BIT]),
    .pulse_q (ext_irq_three_falling)
  );

  edge_catch #(.RISING(1'b1)) u_irq_four (
    .clk_sys (clk_sys),
    .rst_n   (rst_sync_n),
    .level   (gen_one_read[`G1_IRQ4_BIT]),
    .pulse_q (ext_irq_four_rising)
  );

  edge_catch #(.RISING(1'b0)) u_irq_five (
    .clk_sys (clk_sys),
    .rst_n   (rst_sync_n),
    .level   (gen_one_read[`G1_IRQ5_BIT]),
    .pulse_q (ext_irq_five_falling)
  );

  // ----------------------------------------------------------------
  // Multi-function port
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] multi_alt;

  // Strobes pull low through the same quasi driver; latch must stay at one
  always_comb begin
    multi_alt                  = '1;
    multi_alt[`MF_SER0_TX_BIT] = serial_zero_transmit;
    multi_alt[`MF_WR_BIT]      = xdata_wr_strobe_n;
    multi_alt[`MF_RD_BIT]      = xdata_rd_strobe_n;
  end

  quasi_port #(
    .WIDTH      (WIDTH),
    .STRONG_CYC (`STRONG_PULL_CYC),
    .RST_VAL    (`PORT_RESET)
  ) u_multi (
    .clk_sys   (clk_sys),
    .rst_n     (rst_sync_n),
    .wr_en     (multi_wr_en),
    .wr_data   (multi_wr_data),
    .alt_out   (multi_alt),
    .latch_q   (multi_latch),
    .pin_level (multi_read),
    .pin_in    (multi_function_port_in),
    .pin_out   (multi_function_port_out),
    .pin_oe    (multi_function_port_oe),
    .pullup_en (multi_function_port_pullup)
  );

  assign serial_zero_receive = multi_read[`MF_SER0_RX_BIT];
  assign ext_irq_zero        = multi_read[`MF_IRQ0_BIT];
  assign ext_irq_one         = multi_read[`MF_IRQ1_BIT];
  assign timer_zero_count_in = multi_read[`MF_TMR0_BIT];
  assign timer_one_count_in  = multi_read[`MF_TMR1_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_sync_n);

  sequence s_mf2_rise;
    !multi_latch[2] && multi_wr_en && multi_wr_data[2];
  endsequence

  sequence s_g1_rise;
    !gen_one_latch[6] && gen_one_wr_en && gen_one_wr_data[6];
  endsequence

  sequence s_strong_then_weak(logic oe);
    oe [*2] ##1 !oe;
  endsequence

  a_addr_direct: assert property (
    mem_access && !mem_indirect |=> upper_address_port == $past(mem_addr[15:8]))
    else $error("address high byte not driven");

  a_addr_order: assert property (
    mem_access && !mem_indirect |=> upper_address_port[7] == $past(mem_addr[15])
      && upper_address_port[0] == $past(mem_addr[8]))
    else $error("address bit order wrong");

  a_latch_readback: assert property (
    upper_wr_en |=> upper_latch == $past(upper_wr_data))
    else $error("upper latch not readable");

  a_latch_hidden: assert property (
    !mem_access |=> $stable(upper_address_port))
    else $error("upper latch leaked to pins");

  a_addr_indirect: assert property (
    mem_access && mem_indirect && !upper_wr_en
      |=> upper_address_port == $past(upper_latch))
    else $error("indirect move lost latch byte");

  a_reset_ones: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_sync_n) |-> multi_latch == `PORT_RESET
      && multi_function_port_pullup == `PORT_RESET && multi_function_port_oe == 8'h00)
    else $error("multi port not all ones after reset");

  a_weak_input: assert property (
    multi_latch[2] && $stable(multi_latch[2]) && !$rose(multi_latch[2])
      ##1 multi_latch[2] [*2] |-> !multi_function_port_oe[2])
    else $error("latched one still strongly driven");

  a_pulldown_hold: assert property (
    multi_wr_en && !multi_wr_data[2] ##1 !multi_wr_en [*2]
      |-> multi_function_port_oe[2] && !multi_function_port_out[2])
    else $error("pulldown not held on written zero");

  a_strong_pulse: assert property (
    s_mf2_rise |=> ##1 s_strong_then_weak(multi_function_port_oe[2]))
    else $error("strong pullup pulse wrong length");

  a_g1_quasi: assert property (
    s_g1_rise and !xdata_rd |=> ##1 s_strong_then_weak(general_port_one_oe[6]))
    else $error("port one pullup pulse wrong");

  a_irq_rising: assert property (
    $rose(gen_one_read[4]) |=> ext_irq_two_rising ##1 !ext_irq_two_rising)
    else $error("rising edge irq missed");

  a_irq_falling: assert property (
    $fell(gen_one_read[7]) |=> ext_irq_five_falling ##1 !ext_irq_five_falling)
    else $error("falling edge irq missed");

  a_pin_read: assert property (
    ##2 multi_read[3] == $past(multi_function_port_in[3], 2))
    else $error("read not from pin level");

  a_strobe_idle: assert property (
    !(mem_access && (xdata_rd || xdata_wr)) |=> xdata_rd_strobe_n && xdata_wr_strobe_n)
    else $error("strobe active outside transfer");

  a_wr_on_pin: assert property (
    !xdata_wr_strobe_n |=> multi_function_port_oe[6] && !multi_function_port_out[6])
    else $error("write strobe not on pin");

  a_rd_on_pin: assert property (
    mem_access && xdata_rd |=> !xdata_rd_strobe_n
      ##1 multi_function_port_oe[7] && !multi_function_port_out[7])
    else $error("read strobe not on pin");

endmodule

// >>> port_defines.svh
// Constants for the port pin logic: bit positions, reset values, timing
`ifndef PORT_DEFINES_SVH
`define PORT_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   10
`define STRONG_PULL_NS  20
`define STRONG_PULL_CYC ((`STRONG_PULL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------
`define PORT_WIDTH      8
`define PORT_RESET      8'hFF

// ----------------------------------------------------------------
// General port one alternate bits
// ----------------------------------------------------------------
`define G1_TIMER2_BIT   0
`define G1_T2TRIG_BIT   1
`define G1_SER1_RX_BIT  2
`define G1_SER1_TX_BIT  3
`define G1_IRQ2_BIT     4
`define G1_IRQ3_BIT     5
`define G1_IRQ4_BIT     6
`define G1_IRQ5_BIT     7

// ----------------------------------------------------------------
// Multi-function port alternate bits
// ----------------------------------------------------------------
`define MF_SER0_RX_BIT  0
`define MF_SER0_TX_BIT  1
`define MF_IRQ0_BIT     2
`define MF_IRQ1_BIT     3
`define MF_TMR0_BIT     4
`define MF_TMR1_BIT     5
`define MF_WR_BIT       6
`define MF_RD_BIT       7

`endif

// >>> port_pkg.sv
// Types shared by the port pin logic
package port_pkg;

  typedef enum logic [1:0] {
    XFER_IDLE,
    XFER_READ,
    XFER_WRITE
  } xfer_e;

endpackage

// >>> quasi_port.sv
// One quasi-bidirectional port: latch, drivers and pin synchroniser
`timescale 1ns/1ps
`include "port_defines.svh"

module quasi_port #(
  parameter int           WIDTH      = `PORT_WIDTH,
  parameter int           STRONG_CYC = `STRONG_PULL_CYC,
  parameter logic [WIDTH-1:0] RST_VAL = `PORT_RESET
) (
  // Clock and reset
  input  logic             clk_sys,
  input  logic             rst_n,
  // Core side
  input  logic             wr_en,
  input  logic [WIDTH-1:0] wr_data,
  input  logic [WIDTH-1:0] alt_out,
  output logic [WIDTH-1:0] latch_q,
  output logic [WIDTH-1:0] pin_level,
  // Pin side
  input  logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] pullup_en
);

  logic [WIDTH-1:0] drive_q;
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // ----------------------------------------------------------------
  // Latch and pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= RST_VAL;
    end else if (wr_en) begin
      latch_q <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_level = sync_q;

  // ----------------------------------------------------------------
  // Drivers per bit
  // ----------------------------------------------------------------
  // Alternate output of 1 leaves the pin to the latch, 0 pulls it low
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic       drive_d;
    logic [3:0] cnt_q;
    assign drive_d = latch_q[i] & alt_out[i];
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        drive_q[i] <= RST_VAL[i];
        cnt_q      <= 4'h0;
      end else begin
        drive_q[i] <= drive_d;
        if (drive_d && !drive_q[i]) begin
          cnt_q <= 4'(STRONG_CYC);
        end else if (cnt_q != 4'h0) begin
          cnt_q <= cnt_q - 4'h1;
        end
      end
    end
    assign pin_oe[i] = !drive_q[i] || (cnt_q != 4'h0);
  end

  assign pin_out   = drive_q;
  assign pullup_en = drive_q;

endmodule

// >>> edge_catch.sv
// Edge detector on an already synchronised level, one-cycle pulse
`timescale 1ns/1ps

module edge_catch #(
  parameter bit RISING = 1'b1
) (
  // Clock and reset
  input  logic clk_sys,
  input  logic rst_n,
  // Level in, pulse out
  input  logic level,
  output logic pulse_q
);

  logic prev_q;

  // Idle pin sits high, so no false edge after reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_q  <= 1'b1;
      pulse_q <= 1'b0;
    end else begin
      prev_q  <= level;
      pulse_q <= RISING ? (level & ~prev_q) : (~level & prev_q);
    end
  end

endmodule

// >>> board_port_model.sv
// Board-side model of one quasi-bidirectional port: loads and external pulls
`timescale 1ns/1ps

module board_port_model (
  // Clock for the floating-pin pattern
  input  wire logic       clk_sys,
  // Device drivers
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  // Pulls commanded by the bench
  input  wire logic [7:0] ext_low,
  // Resolved pin level
  output logic      [7:0] pin_level
);
  logic float_q;

  initial float_q = 1'b0;

  // Undriven pin with no pullup and no external low wanders, so a stale level never reads as valid
  always @(posedge clk_sys) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i])
        pin_level[i] = pin_out[i];
      else if (ext_low[i])
        pin_level[i] = 1'b0;
      else if (pin_pullup[i])
        pin_level[i] = 1'b1;
      else
        pin_level[i] = float_q;
    end
  end
endmodule

// >>> test_port_pin_logic.sv
// Self-checking testbench for the port pin logic
`timescale 1ns/1ps

module test_port_pin_logic;
  logic        clk_sys, rst_n;
  logic        mem_access, mem_indirect, xdata_rd, xdata_wr;
  logic [15:0] mem_addr;
  logic        upper_wr_en, gen_one_wr_en, multi_wr_en;
  logic [7:0]  upper_wr_data, gen_one_wr_data, multi_wr_data;
  logic [7:0]  upper_latch, gen_one_latch, gen_one_read, multi_latch, multi_read;
  logic        timer_two_out, serial_one_transmit, serial_zero_transmit;
  logic        timer_two_pin, timer_two_trigger_pin, serial_one_receive;
  logic        ext_irq_two_rising, ext_irq_three_falling;
  logic        ext_irq_four_rising, ext_irq_five_falling;
  logic        serial_zero_receive, ext_irq_zero, ext_irq_one;
  logic        timer_zero_count_in, timer_one_count_in;
  logic        xdata_wr_strobe_n, xdata_rd_strobe_n;
  logic [7:0]  upper_address_port;
  logic [7:0]  general_port_one_in, general_port_one_out;
  logic [7:0]  general_port_one_oe, general_port_one_pullup, g1_ext_low;
  logic [7:0]  multi_function_port_in, multi_function_port_out;
  logic [7:0]  multi_function_port_oe, multi_function_port_pullup, mf_ext_low;
  logic [7:0]  v_oe, v_out, v_pu, v_rd, v_lat;
  int          mismatches, n_tests;
  int          cnt [4];

  port_pin_logic i_dut (
    .clk_sys, .rst_n, .mem_access, .mem_addr, .mem_indirect, .xdata_rd, .xdata_wr,
    .upper_wr_en, .upper_wr_data, .upper_latch, .gen_one_wr_en, .gen_one_wr_data,
    .gen_one_latch, .gen_one_read, .multi_wr_en, .multi_wr_data, .multi_latch,
    .multi_read, .timer_two_out, .timer_two_pin, .timer_two_trigger_pin,
    .serial_one_receive, .serial_one_transmit, .ext_irq_two_rising,
    .ext_irq_three_falling, .ext_irq_four_rising, .ext_irq_five_falling,
    .serial_zero_receive, .serial_zero_transmit, .ext_irq_zero, .ext_irq_one,
    .timer_zero_count_in, .timer_one_count_in, .xdata_wr_strobe_n, .xdata_rd_strobe_n,
    .upper_address_port, .general_port_one_in, .general_port_one_out,
    .general_port_one_oe, .general_port_one_pullup, .multi_function_port_in,
    .multi_function_port_out, .multi_function_port_oe, .multi_function_port_pullup
  );

  board_port_model i_board_one (
    .clk_sys(clk_sys), .pin_out(general_port_one_out), .pin_oe(general_port_one_oe),
    .pin_pullup(general_port_one_pullup), .ext_low(g1_ext_low),
    .pin_level(general_port_one_in)
  );

  board_port_model i_board_multi (
    .clk_sys(clk_sys), .pin_out(multi_function_port_out), .pin_oe(multi_function_port_oe),
    .pin_pullup(multi_function_port_pullup), .ext_low(mf_ext_low),
    .pin_level(multi_function_port_in)
  );

  // ----------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------
  task automatic cyc();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic snap(input bit one);
    v_oe  = one ? general_port_one_oe : multi_function_port_oe;
    v_out = one ? general_port_one_out : multi_function_port_out;
    v_pu  = one ? general_port_one_pullup : multi_function_port_pullup;
    v_rd  = one ? gen_one_read : multi_read;
    v_lat = one ? gen_one_latch : multi_latch;
  endtask

  task automatic wr_q(input bit one, input logic [7:0] d);
    gen_one_wr_en   = one;
    multi_wr_en     = !one;
    gen_one_wr_data = d;
    multi_wr_data   = d;
    cyc();
    gen_one_wr_en = 1'b0;
    multi_wr_en   = 1'b0;
  endtask

  task automatic access(input logic [15:0] a, input logic ind, input logic rd, input logic wr);
    mem_access   = 1'b1;
    mem_addr     = a;
    mem_indirect = ind;
    xdata_rd     = rd;
    xdata_wr     = wr;
    cyc();
    mem_access = 1'b0;
    xdata_rd   = 1'b0;
    xdata_wr   = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    snap(1'b0);
    chk(v_lat, 8'hFF, "multi latch");
    chk(v_oe, 8'h00, "multi oe");
    chk(v_pu, 8'hFF, "multi pullup");
    chk(v_rd, 8'hFF, "multi read");
    snap(1'b1);
    chk({v_lat, v_pu}, 16'hFFFF, "port one latch");
    chk(v_oe, 8'h00, "port one oe");
    chk({xdata_rd_strobe_n, xdata_wr_strobe_n}, 2'b11, "strobes idle");
  endtask

  task automatic t_addr();
    logic [15:0] a [4] = '{16'h1234, 16'hA5C3, 16'h00FF, 16'hFF00};
    foreach (a[i]) begin
      access(a[i], 1'b0, 1'b0, 1'b0);
      chk(upper_address_port, a[i][15:8], "address byte");
      chk({upper_address_port[7], upper_address_port[0]}, {a[i][15], a[i][8]}, "bit order");
      cyc();
    end
    upper_wr_en   = 1'b1;
    upper_wr_data = 8'h3C;
    cyc();
    upper_wr_en = 1'b0;
    chk(upper_latch, 8'h3C, "upper latch");
    cyc();
    chk(upper_address_port, 8'hFF, "latch off idle pins");
    access(16'h8100, 1'b0, 1'b0, 1'b0);
    chk(upper_address_port, 8'h81, "latch kept off pins");
    cyc();
    access(16'h00AA, 1'b1, 1'b0, 1'b0);
    chk(upper_address_port, 8'h3C, "indirect high byte");
  endtask

  task automatic t_quasi(input bit one);
    wr_q(one, 8'hB3);
    snap(one);
    chk(v_lat, 8'hB3, "latch zero");
    cyc();
    snap(one);
    chk({v_oe[3], v_out[3]}, 2'b10, "strong pulldown");
    repeat (5) cyc();
    snap(one);
    chk({v_oe[3], v_out[3]}, 2'b10, "pulldown held");
    chk(v_rd, 8'hB3, "read pin low");
    wr_q(one, 8'hFF);
    cyc();
    snap(one);
    chk({v_oe[3], v_out[3]}, 2'b11, "strong pullup");
    cyc();
    snap(one);
    chk(v_oe[3], 1'b1, "strong pullup second cycle");
    cyc();
    snap(one);
    chk({v_oe, v_pu}, 16'h00FF, "weak pullup back");
  endtask

  task automatic t_inputs();
    mf_ext_low = 8'h3D;
    g1_ext_low = 8'h07;
    repeat (5) cyc();
    chk(multi_read, 8'hC2, "pin level read");
    chk(multi_latch, 8'hFF, "latch still one");
    chk(serial_zero_receive, 1'b0, "serial zero rx");
    chk({ext_irq_zero, ext_irq_one, timer_zero_count_in, timer_one_count_in}, 4'h0, "irq tmr");
    chk({timer_two_pin, timer_two_trigger_pin, serial_one_receive}, 3'b000, "port one alt");
    mf_ext_low = 8'h00;
    g1_ext_low = 8'h00;
    repeat (5) cyc();
    chk({ext_irq_zero, ext_irq_one, timer_zero_count_in, timer_one_count_in}, 4'hF, "irq tmr");
    chk({serial_zero_receive, timer_two_pin, timer_two_trigger_pin, serial_one_receive},
        4'hF, "alt inputs high");
  endtask

  task automatic t_irq(input logic [7:0] pull, input logic [3:0] exp);
    cnt = '{0, 0, 0, 0};
    g1_ext_low = pull;
    for (int i = 0; i < 8; i++) begin
      cyc();
      cnt[0] += ext_irq_two_rising;
      cnt[1] += ext_irq_three_falling;
      cnt[2] += ext_irq_four_rising;
      cnt[3] += ext_irq_five_falling;
    end
    chk({cnt[0][3:0], cnt[2][3:0]}, {3'b000, exp[0], 3'b000, exp[2]}, "rising pulses");
    chk({cnt[1][3:0], cnt[3][3:0]}, {3'b000, exp[1], 3'b000, exp[3]}, "falling pulses");
  endtask

  task automatic t_strobe();
    for (int r = 0; r < 2; r++) begin
      access(16'h4000, 1'b0, r[0], !r[0]);
      chk({xdata_rd_strobe_n, xdata_wr_strobe_n}, {!r[0], r[0]}, "strobe low");
      cyc();
      chk({multi_function_port_oe[r ? 7 : 6], multi_function_port_out[r ? 7 : 6]},
          2'b10, "strobe pin low");
      chk({xdata_rd_strobe_n, xdata_wr_strobe_n}, 2'b11, "strobe released");
      repeat (4) cyc();
    end
  endtask

  task automatic t_alt_out();
    serial_zero_transmit = 1'b0;
    serial_one_transmit  = 1'b0;
    timer_two_out        = 1'b0;
    repeat (4) cyc();
    chk({multi_function_port_oe[1], multi_function_port_out[1]}, 2'b10, "serial zero tx");
    chk({general_port_one_oe[3], general_port_one_out[3]}, 2'b10, "serial one tx");
    chk({general_port_one_oe[0], general_port_one_out[0]}, 2'b10, "timer two out");
    serial_zero_transmit = 1'b1;
    serial_one_transmit  = 1'b1;
    timer_two_out        = 1'b1;
    repeat (6) cyc();
    chk({multi_function_port_oe[1], general_port_one_oe[3], general_port_one_oe[0]},
        3'b000, "alt outputs released");
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    {rst_n, mem_access, mem_indirect, xdata_rd, xdata_wr} = '0;
    {upper_wr_en, gen_one_wr_en, multi_wr_en} = '0;
    {mem_addr, upper_wr_data, gen_one_wr_data, multi_wr_data} = '0;
    {timer_two_out, serial_one_transmit, serial_zero_transmit} = 3'b111;
    g1_ext_low = 8'h00;
    mf_ext_low = 8'h00;
    mismatches = 0;
    n_tests    = 0;
    repeat (16) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    repeat (4) cyc();
    t_reset();
    t_addr();
    t_quasi(1'b0);
    t_quasi(1'b1);
    t_inputs();
    t_irq(8'hF0, 4'b1010);
    t_irq(8'h00, 4'b0101);
    t_strobe();
    t_alt_out();
    tally_and_finish();
  end

  // Whole run is about a hundred cycles; this leaves ample margin
  initial begin
    #50000;
    mismatches++;
    tally_and_finish();
  end
endmodule
